// ==== sirq_pkg.sv ====
package sirq_pkg;

	// ==========================================================
	// Register offsets, memory window and configuration aliases
	localparam logic [7:0] MEM_MODE_OFF = 8'h48;
	localparam logic [7:0] MEM_SENSE_OFF = 8'h4a;
	localparam logic [7:0] MEM_STAT_OFF = 8'h4c;
	localparam logic [7:0] CFG_MODE_OFF = 8'he0;
	localparam logic [7:0] CFG_SENSE_OFF = 8'he2;
	localparam logic [7:0] CFG_STAT_OFF = 8'he4;

	// ==========================================================
	// Reset values and field layout
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [15:0] SENSE_RESET = 16'h0000;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [7:0] MODE_WRITABLE = 8'h0f;
	localparam int DRIVE_BIT = 0;
	localparam int POLL_BIT = 1;
	localparam int WIDTH_LSB = 2;
	localparam int NUM_SLOTS = 16;

	// ==========================================================
	// Start frame width codes and clock counts
	localparam logic [1:0] WIDTH_CODE_4 = 2'h0;
	localparam logic [1:0] WIDTH_CODE_6 = 2'h1;
	localparam logic [1:0] WIDTH_CODE_8 = 2'h2;
	localparam logic [3:0] START_CLKS_4 = 4'h4;
	localparam logic [3:0] START_CLKS_6 = 4'h6;
	localparam logic [3:0] START_CLKS_8 = 4'h8;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} sirq_acc_t;

	typedef struct packed {
		logic valid;
		logic [3:0] index;
		logic asserted;
	} sirq_slot_t;

	// Reserved code falls back to the shortest frame
	function automatic logic [3:0] start_clks(input logic [1:0] code);
		case (code)
			WIDTH_CODE_6: start_clks = START_CLKS_6;
			WIDTH_CODE_8: start_clks = START_CLKS_8;
			default: start_clks = START_CLKS_4;
		endcase
	endfunction

	function automatic logic [15:0] byte_mask(input logic [1:0] be);
		byte_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

endpackage

// ==== sirq_reg_port.sv ====
`timescale 1ns/10ps
module sirq_reg_port #(
	parameter logic [7:0] MODE_OFF = 8'h00,
	parameter logic [7:0] SENSE_OFF = 8'h00,
	parameter logic [7:0] STAT_OFF = 8'h00
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire sirq_pkg::sirq_acc_t i_acc,
	input wire logic [7:0] i_mode,
	input wire logic [15:0] i_sense,
	input wire logic [15:0] i_status,
	output logic o_wr_mode,
	output logic o_wr_sense,
	output logic o_wr_stat,
	output logic [15:0] o_wmask,
	output logic [15:0] o_rdata,
	output logic o_rvalid
);

	logic wr;
	logic rd;

	assign wr = i_acc.valid && i_acc.write;
	assign rd = i_acc.valid && !i_acc.write;
	assign o_wr_mode = wr && (i_acc.addr == MODE_OFF);
	assign o_wr_sense = wr && (i_acc.addr == SENSE_OFF);
	assign o_wr_stat = wr && (i_acc.addr == STAT_OFF);
	assign o_wmask = sirq_pkg::byte_mask(i_acc.be) & i_acc.wdata;

	// ==========================================================
	// Read path, unmapped offsets answer zero
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= rd;
			if (rd && i_acc.addr == MODE_OFF) begin
				o_rdata <= {8'h00, i_mode & sirq_pkg::MODE_WRITABLE};
			end else if (rd && i_acc.addr == SENSE_OFF) begin
				o_rdata <= i_sense;
			end else if (rd && i_acc.addr == STAT_OFF) begin
				o_rdata <= i_status;
			end else begin
				o_rdata <= 16'h0000;
			end
		end
	end

endmodule

// ==== sirq_start_frame.sv ====
`timescale 1ns/10ps
module sirq_start_frame (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic [1:0] i_width,
	output logic o_active
);

	typedef enum logic {SF_IDLE, SF_DRIVE} sirq_sf_state_t;

	sirq_sf_state_t state;
	logic [3:0] remain;

	assign o_active = (state == SF_DRIVE);

	// Width latched at the go pulse so a mid-frame write cannot stretch it
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= SF_IDLE;
			remain <= 4'h0;
		end else begin
			case (state)
				SF_IDLE: begin
					if (i_go) begin
						state <= SF_DRIVE;
						remain <= sirq_pkg::start_clks(i_width) - 4'h1;
					end
				end
				SF_DRIVE: begin
					if (remain == 4'h0) begin
						state <= SF_IDLE;
					end else begin
						remain <= remain - 4'h1;
					end
				end
				default: begin
					state <= SF_IDLE;
				end
			endcase
		end
	end

endmodule

// ==== sirq_ctrl.sv ====
`timescale 1ns/10ps
// Summary of operation
// (RULE1) Start frame lasts 4, 6 or 8 clocks by two-bit code; 11 reserved.
// (RULE2) Poll bit clear means continuous mode, set means quiet mode.
// (RULE3) Recovery cycle drives line high if drive bit clear, else floats.
// (RULE4) Sixteen per-slot sense bits: zero edge, one level sensing.
// (RULE5) Asserted level-sensed slot sets its status bit.
// (RULE6) Writing one to a status bit clears it and re-arms the slot.
// (RULE7) Edge-sensed slots never set their status bit.
// (RULE8) Mode register bits 7:4 always read zero.
// (RULE9) Link, global and power-on reset clear mode, sense and status.
// (RULE10) Reset state: continuous, four-clock start, drive high, all edge.
// (RULE11) Memory window and configuration views share the same storage.
// (RULE12) Status bit stays set until software writes one to it.
module sirq_ctrl (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_link_rst,
	input wire logic i_global_reset_input,
	input wire sirq_pkg::sirq_acc_t i_mem_acc,
	input wire sirq_pkg::sirq_acc_t i_cfg_acc,
	input wire sirq_pkg::sirq_slot_t i_slot,
	input wire logic i_frame_go,
	input wire logic i_recovery,
	output logic [15:0] o_mem_rdata,
	output logic o_mem_rvalid,
	output logic [15:0] o_cfg_rdata,
	output logic o_cfg_rvalid,
	output logic o_quiet_polling_select,
	output logic [15:0] o_slot_sense_select,
	output logic [15:0] o_slot_level_asserted,
	output logic o_start_active,
	output logic o_serirq_o,
	output logic o_serirq_oe
);

	// ==========================================================
	// Reset gathering
	logic link_meta;
	logic link_sync;
	logic global_reset_input_meta;
	logic global_reset_input_sync;
	logic clr;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			link_meta <= 1'b1;
			link_sync <= 1'b1;
			global_reset_input_meta <= 1'b1;
			global_reset_input_sync <= 1'b1;
		end else begin
			link_meta <= i_link_rst;
			link_sync <= link_meta;
			global_reset_input_meta <= i_global_reset_input;
			global_reset_input_sync <= global_reset_input_meta;
		end
	end

	assign clr = i_rst || link_sync || global_reset_input_sync; // RULE9

	// ==========================================================
	// Storage shared by both views
	logic [7:0] mode;
	logic [15:0] sense;
	logic [15:0] status;
	logic [15:0] next_status;
	logic recovery_tristate;
	logic [1:0] start_width;

	logic mem_wr_mode;
	logic mem_wr_sense;
	logic mem_wr_stat;
	logic [15:0] mem_wmask;
	logic cfg_wr_mode;
	logic cfg_wr_sense;
	logic cfg_wr_stat;
	logic [15:0] cfg_wmask;
	logic [15:0] sense_be_mem;
	logic [15:0] sense_be_cfg;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;

	sirq_reg_port #(
		.MODE_OFF(sirq_pkg::MEM_MODE_OFF),
		.SENSE_OFF(sirq_pkg::MEM_SENSE_OFF),
		.STAT_OFF(sirq_pkg::MEM_STAT_OFF)
	) u_mem_port (
		.i_mclk(i_mclk),
		.i_rst(clr),
		.i_acc(i_mem_acc),
		.i_mode(mode),
		.i_sense(sense),
		.i_status(status),
		.o_wr_mode(mem_wr_mode),
		.o_wr_sense(mem_wr_sense),
		.o_wr_stat(mem_wr_stat),
		.o_wmask(mem_wmask),
		.o_rdata(o_mem_rdata),
		.o_rvalid(o_mem_rvalid)
	);

	sirq_reg_port #(
		.MODE_OFF(sirq_pkg::CFG_MODE_OFF),
		.SENSE_OFF(sirq_pkg::CFG_SENSE_OFF),
		.STAT_OFF(sirq_pkg::CFG_STAT_OFF)
	) u_cfg_port (
		.i_mclk(i_mclk),
		.i_rst(clr),
		.i_acc(i_cfg_acc),
		.i_mode(mode),
		.i_sense(sense),
		.i_status(status),
		.o_wr_mode(cfg_wr_mode),
		.o_wr_sense(cfg_wr_sense),
		.o_wr_stat(cfg_wr_stat),
		.o_wmask(cfg_wmask),
		.o_rdata(o_cfg_rdata),
		.o_rvalid(o_cfg_rvalid)
	);

	assign sense_be_mem = sirq_pkg::byte_mask(i_mem_acc.be);
	assign sense_be_cfg = sirq_pkg::byte_mask(i_cfg_acc.be);

	// Configuration view checked first, so it wins a same-cycle collision
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			mode <= sirq_pkg::MODE_RESET; // RULE10
		end else if (cfg_wr_mode && i_cfg_acc.be[0]) begin
			mode <= cfg_wmask[7:0] & sirq_pkg::MODE_WRITABLE; // RULE8 RULE11
		end else if (mem_wr_mode && i_mem_acc.be[0]) begin
			mode <= mem_wmask[7:0] & sirq_pkg::MODE_WRITABLE; // RULE8 RULE11
		end
	end

	always_ff @(posedge i_mclk) begin
		if (clr) begin
			sense <= sirq_pkg::SENSE_RESET; // RULE10
		end else if (cfg_wr_sense) begin
			sense <= (sense & ~sense_be_cfg) | cfg_wmask; // RULE4 RULE11
		end else if (mem_wr_sense) begin
			sense <= (sense & ~sense_be_mem) | mem_wmask; // RULE4 RULE11
		end
	end

	// ==========================================================
	// Level status capture and re-arm
	always_comb begin
		set_vec = 16'h0000;
		if (i_slot.valid && i_slot.asserted && sense[i_slot.index]) begin
			set_vec[i_slot.index] = 1'b1; // RULE5 RULE7
		end
		clr_vec = (mem_wr_stat ? mem_wmask : 16'h0000) | (cfg_wr_stat ? cfg_wmask : 16'h0000);
		next_status = (status & ~clr_vec) | set_vec; // RULE6 RULE12
	end

	always_ff @(posedge i_mclk) begin
		if (clr) begin
			status <= sirq_pkg::STAT_RESET; // RULE9
		end else begin
			status <= next_status;
		end
	end

	// ==========================================================
	// Mode outputs and line drive
	assign start_width = mode[sirq_pkg::WIDTH_LSB +: 2];
	assign recovery_tristate = mode[sirq_pkg::DRIVE_BIT];
	assign o_quiet_polling_select = mode[sirq_pkg::POLL_BIT]; // RULE2
	assign o_slot_sense_select = sense;
	assign o_slot_level_asserted = status;

	sirq_start_frame u_start (
		.i_mclk(i_mclk),
		.i_rst(clr),
		.i_go(i_frame_go),
		.i_width(start_width), // RULE1
		.o_active(o_start_active)
	);

	// Start frame pulls low; recovery drives high or floats
	always_ff @(posedge i_mclk) begin
		if (clr) begin
			o_serirq_o <= 1'b1;
			o_serirq_oe <= 1'b0;
		end else if (o_start_active) begin
			o_serirq_o <= 1'b0;
			o_serirq_oe <= 1'b1; // RULE1
		end else if (i_recovery) begin
			o_serirq_o <= 1'b1;
			o_serirq_oe <= !recovery_tristate; // RULE3
		end else begin
			o_serirq_o <= 1'b1;
			o_serirq_oe <= 1'b0;
		end
	end

	// ==========================================================
	// Checks
	sequence start_run4;
		o_start_active [*4] ##1 !o_start_active;
	endsequence

	sequence start_run6;
		o_start_active [*6] ##1 !o_start_active;
	endsequence

	sequence start_run8;
		o_start_active [*8] ##1 !o_start_active;
	endsequence

	start_four_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE1
		$rose(o_start_active) && $past(start_width) != sirq_pkg::WIDTH_CODE_6
		&& $past(start_width) != sirq_pkg::WIDTH_CODE_8 |-> start_run4)
		else $error("start frame not four clocks");

	start_six_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE1
		$rose(o_start_active) && $past(start_width) == sirq_pkg::WIDTH_CODE_6 |-> start_run6)
		else $error("start frame not six clocks");

	start_eight_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE1
		$rose(o_start_active) && $past(start_width) == sirq_pkg::WIDTH_CODE_8 |-> start_run8)
		else $error("start frame not eight clocks");

	poll_follow_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE2
		cfg_wr_mode && i_cfg_acc.be[0] |=> o_quiet_polling_select == $past(i_cfg_acc.wdata[1]))
		else $error("poll mode did not follow write");

	recovery_drive_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE3
		i_recovery && !o_start_active |=> o_serirq_o && (o_serirq_oe == !$past(recovery_tristate)))
		else $error("recovery drive wrong");

	level_set_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE5
		i_slot.valid && i_slot.asserted && sense[i_slot.index]
		|=> status[$past(i_slot.index)])
		else $error("level slot not recorded");

	edge_never_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE7
		##1 ((status & ~$past(status) & ~$past(sense)) == 16'h0000))
		else $error("edge slot set status");

	rearm_clear_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE6
		##1 (($past(clr_vec) & ~$past(set_vec) & status) == 16'h0000))
		else $error("status not cleared by write one");

	status_hold_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE12
		##1 (($past(status) & ~$past(clr_vec) & ~status) == 16'h0000))
		else $error("status dropped without write one");

	reserved_zero_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE8
		o_mem_rvalid |-> o_mem_rdata[7:4] == 4'h0 || $past(i_mem_acc.addr) != sirq_pkg::MEM_MODE_OFF)
		else $error("reserved mode bits read nonzero");

	reset_clear_a: assert property (@(posedge i_mclk) // RULE9 RULE10
		clr |=> mode == sirq_pkg::MODE_RESET && sense == sirq_pkg::SENSE_RESET
		&& status == sirq_pkg::STAT_RESET)
		else $error("reset did not clear registers");

	alias_view_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE11
		i_mem_acc.valid && !i_mem_acc.write && i_mem_acc.addr == sirq_pkg::MEM_STAT_OFF
		&& i_cfg_acc.valid && !i_cfg_acc.write && i_cfg_acc.addr == sirq_pkg::CFG_STAT_OFF
		|=> o_mem_rdata == o_cfg_rdata)
		else $error("views disagree");

	// ==========================================================
	// Line drive, reset and second-view checks
	start_low_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE1
		o_start_active |=> !o_serirq_o && o_serirq_oe)
		else $error("start frame not driven low");
	idle_release_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE3
		!o_start_active && !i_recovery |=> o_serirq_o && !o_serirq_oe)
		else $error("idle line not released");
	poll_mem_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE2
		mem_wr_mode && i_mem_acc.be[0] && !cfg_wr_mode
		|=> o_quiet_polling_select == $past(i_mem_acc.wdata[sirq_pkg::POLL_BIT]))
		else $error("poll mode did not follow memory write");
	sense_follow_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE4
		cfg_wr_sense && i_cfg_acc.be == 2'h3
		|=> o_slot_sense_select == $past(i_cfg_acc.wdata))
		else $error("sense did not follow write");
	cfg_rearm_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE6
		cfg_wr_stat && !i_slot.valid
		|=> (o_slot_level_asserted & $past(cfg_wmask)) == 16'h0000)
		else $error("config write one did not clear");
	cfg_reserved_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE8
		o_cfg_rvalid && $past(i_cfg_acc.addr) == sirq_pkg::CFG_MODE_OFF
		|-> o_cfg_rdata[7:4] == 4'h0)
		else $error("reserved mode bits nonzero on config view");
	reset_line_a: assert property (@(posedge i_mclk) // RULE10
		clr |=> o_serirq_o && !o_serirq_oe && !o_start_active && !o_quiet_polling_select)
		else $error("reset did not release the line");
	alias_mode_a: assert property (@(posedge i_mclk) disable iff (clr) // RULE11
		i_mem_acc.valid && !i_mem_acc.write && i_mem_acc.addr == sirq_pkg::MEM_MODE_OFF
		&& i_cfg_acc.valid && !i_cfg_acc.write && i_cfg_acc.addr == sirq_pkg::CFG_MODE_OFF
		|=> o_mem_rdata == o_cfg_rdata)
		else $error("mode views disagree");

endmodule

// ==== sirq_periph.sv ====
`timescale 1ns/10ps
// ==========
// Far-side slot source
module sirq_periph (
	input wire logic i_mclk,
	input wire logic i_req,
	input wire logic [3:0] i_index,
	input wire logic i_level,
	output sirq_pkg::sirq_slot_t o_slot
);
	// Idle cycles invert the stale fields each cycle, so every second idle cycle shows the last slot again
	always_ff @(posedge i_mclk) begin
		o_slot.valid <= i_req;
		o_slot.index <= i_req ? i_index : ~o_slot.index;
		o_slot.asserted <= i_req ? i_level : ~o_slot.asserted;
	end
endmodule

// ==== test_serial_irq_mode_edge_status_regs.sv ====
`timescale 1ns/10ps
module test_serial_irq_mode_edge_status_regs;
	logic i_mclk, i_rst, i_link_rst, i_global_reset_input;
	logic i_frame_go, i_recovery, req, lvl, rv;
	logic [3:0] idx;
	logic [15:0] rd, o_mem_rdata, o_cfg_rdata, o_slot_sense_select;
	logic [15:0] o_slot_level_asserted;
	logic o_mem_rvalid, o_cfg_rvalid, o_quiet_polling_select;
	logic o_start_active, o_serirq_o, o_serirq_oe;
	sirq_pkg::sirq_acc_t i_mem_acc, i_cfg_acc;
	sirq_pkg::sirq_slot_t slot;
	int errors, checks_done, n, m;

	sirq_ctrl u_sirq_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_link_rst(i_link_rst),
		.i_global_reset_input(i_global_reset_input), .i_mem_acc(i_mem_acc),
		.i_cfg_acc(i_cfg_acc), .i_slot(slot), .i_frame_go(i_frame_go),
		.i_recovery(i_recovery), .o_mem_rdata(o_mem_rdata), .o_mem_rvalid(o_mem_rvalid),
		.o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
		.o_quiet_polling_select(o_quiet_polling_select),
		.o_slot_sense_select(o_slot_sense_select),
		.o_slot_level_asserted(o_slot_level_asserted), .o_start_active(o_start_active),
		.o_serirq_o(o_serirq_o), .o_serirq_oe(o_serirq_oe));
	sirq_periph u_sirq_periph (.i_mclk(i_mclk), .i_req(req), .i_index(idx),
		.i_level(lvl), .o_slot(slot));

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// ==========
	// Helpers
	task end_of_test;
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task acc(input logic cfg, input logic wr, input logic [7:0] ad,
		input logic [15:0] wd, input logic [1:0] be);
		sirq_pkg::sirq_acc_t a;
		a = '{valid: 1'b1, write: wr, addr: ad, be: be, wdata: wd};
		@(posedge i_mclk);
		if (cfg) i_cfg_acc <= a;
		else i_mem_acc <= a;
		@(posedge i_mclk);
		i_cfg_acc <= '0;
		i_mem_acc <= '0;
		#1;
		rd = cfg ? o_cfg_rdata : o_mem_rdata;
		rv = cfg ? o_cfg_rvalid : o_mem_rvalid;
	endtask

	// Read answer must be valid and equal exp
	task rdc(input logic cfg, input logic [7:0] ad, input logic [15:0] exp);
		acc(cfg, 1'b0, ad, 16'h0000, 2'h3);
		chk({15'h0000, rv}, 16'h0001);
		chk(rd, exp);
	endtask

	// Same-cycle read on both views
	task dual_rd(input logic [7:0] ma, input logic [7:0] ca, input logic [15:0] exp);
		@(posedge i_mclk);
		i_mem_acc <= '{valid: 1'b1, write: 1'b0, addr: ma, be: 2'h3, wdata: 16'h0000};
		i_cfg_acc <= '{valid: 1'b1, write: 1'b0, addr: ca, be: 2'h3, wdata: 16'h0000};
		@(posedge i_mclk);
		i_mem_acc <= '0;
		i_cfg_acc <= '0;
		#1;
		chk(o_mem_rdata, exp);
		chk(o_cfg_rdata, exp);
	endtask

	task slot_ev(input logic [3:0] i, input logic l);
		@(posedge i_mclk);
		req <= 1'b1;
		idx <= i;
		lvl <= l;
		@(posedge i_mclk);
		req <= 1'b0;
	endtask

	task ext_rst(input logic glob);
		acc(1'b0, 1'b1, sirq_pkg::MEM_SENSE_OFF, 16'hffff, 2'h3);
		@(posedge i_mclk);
		if (glob) i_global_reset_input <= 1'b1;
		else i_link_rst <= 1'b1;
		repeat (4) @(posedge i_mclk);
		i_global_reset_input <= 1'b0;
		i_link_rst <= 1'b0;
		repeat (4) @(posedge i_mclk);
		rdc(1'b0, sirq_pkg::MEM_SENSE_OFF, 16'h0000);
		rdc(1'b1, sirq_pkg::CFG_MODE_OFF, 16'h0000);
		rdc(1'b0, sirq_pkg::MEM_STAT_OFF, 16'h0000);
	endtask

	// ==========
	// Scenarios
	task t_reset;
		rdc(1'b0, sirq_pkg::MEM_MODE_OFF, 16'h0000);
		rdc(1'b1, sirq_pkg::CFG_SENSE_OFF, 16'h0000);
		rdc(1'b0, sirq_pkg::MEM_STAT_OFF, 16'h0000);
		chk({14'h0000, o_serirq_o, o_serirq_oe}, 16'h0002);
	endtask

	task t_mode;
		acc(1'b0, 1'b1, sirq_pkg::MEM_MODE_OFF, 16'h00fe, 2'h3);
		rdc(1'b1, sirq_pkg::CFG_MODE_OFF, 16'h000e);
		dual_rd(sirq_pkg::MEM_MODE_OFF, sirq_pkg::CFG_MODE_OFF, 16'h000e);
		chk({15'h0000, o_quiet_polling_select}, 16'h0001);
		rdc(1'b0, 8'h40, 16'h0000);
		acc(1'b1, 1'b1, sirq_pkg::CFG_MODE_OFF, 16'h0000, 2'h1);
		chk({15'h0000, o_quiet_polling_select}, 16'h0000);
	endtask

	task t_width;
		for (int c = 0; c < 4; c++) begin
			acc(1'b0, 1'b1, sirq_pkg::MEM_MODE_OFF, 16'(c * 4), 2'h1);
			@(posedge i_mclk);
			i_frame_go <= 1'b1;
			@(posedge i_mclk);
			i_frame_go <= 1'b0;
			n = 0;
			m = 0;
			repeat (12) begin
				#1;
				n += int'(o_start_active === 1'b1);
				m += int'(o_serirq_oe === 1'b1 && o_serirq_o === 1'b0);
				@(posedge i_mclk);
			end
			chk(16'(n), c == 1 ? 16'h0006 : c == 2 ? 16'h0008 : 16'h0004);
			chk(16'(m), c == 1 ? 16'h0006 : c == 2 ? 16'h0008 : 16'h0004);
		end
	endtask

	task t_drive;
		for (int d = 0; d < 2; d++) begin
			acc(1'b0, 1'b1, sirq_pkg::MEM_MODE_OFF, 16'(d), 2'h1);
			@(posedge i_mclk);
			i_recovery <= 1'b1;
			repeat (2) @(posedge i_mclk);
			i_recovery <= 1'b0;
			#1;
			chk({14'h0000, o_serirq_o, o_serirq_oe}, {14'h0000, 1'b1, d == 0});
		end
	endtask

	// Slots whose sense bit is clear must never latch
	task t_status;
		acc(1'b1, 1'b1, sirq_pkg::CFG_SENSE_OFF, 16'ha5c3, 2'h3);
		rdc(1'b0, sirq_pkg::MEM_SENSE_OFF, 16'ha5c3);
		chk(o_slot_sense_select, 16'ha5c3);
		for (int s = 0; s < 16; s++)
			slot_ev(4'(s), 1'b1);
		slot_ev(4'h0, 1'b0);
		rdc(1'b1, sirq_pkg::CFG_STAT_OFF, 16'ha5c3);
		chk(o_slot_level_asserted, 16'ha5c3);
		acc(1'b0, 1'b1, sirq_pkg::MEM_STAT_OFF, 16'hffff, 2'h1);
		rdc(1'b0, sirq_pkg::MEM_STAT_OFF, 16'ha500);
		slot_ev(4'h1, 1'b1);
		rdc(1'b1, sirq_pkg::CFG_STAT_OFF, 16'ha502);
		dual_rd(sirq_pkg::MEM_STAT_OFF, sirq_pkg::CFG_STAT_OFF, 16'ha502);
		acc(1'b1, 1'b1, sirq_pkg::CFG_STAT_OFF, 16'h0002, 2'h3);
		rdc(1'b0, sirq_pkg::MEM_STAT_OFF, 16'ha500);
	endtask

	initial begin
		errors = 0;
		checks_done = 0;
		i_rst = 1'b1;
		{i_link_rst, i_global_reset_input, i_frame_go, i_recovery} = 4'h0;
		{req, lvl, idx} = 6'h00;
		i_mem_acc = '0;
		i_cfg_acc = '0;
		repeat (4) @(posedge i_mclk);
		i_rst <= 1'b0;
		// Synchronised resets hold the block two more cycles
		repeat (2) @(posedge i_mclk);
		t_reset();
		t_mode();
		t_width();
		t_drive();
		t_status();
		ext_rst(1'b0);
		ext_rst(1'b1);
		end_of_test();
	end

	initial begin
		#100000;
		errors++;
		end_of_test();
	end
endmodule
